// >>> shared/absw_pkg.sv
// Shared constants, types and carriers of the A/B switch rack controller
package absw_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int BAUD_BASIC = 2400;
	localparam int BAUD_NET = 9600;
	localparam int BAUD_BASIC_CYC = CLK_HZ / BAUD_BASIC;
	localparam int BAUD_NET_CYC = CLK_HZ / BAUD_NET;
	localparam int DATA_BITS = 8;
	localparam int STOP_BITS = 1;
	localparam int BOOT_MIN_S = 30;
	localparam int BOOT_CYC = BOOT_MIN_S * CLK_HZ;
	localparam int BLINK_MS = 100;
	localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_B = 8'h42;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] SEC_BASE = 8'h30;
	localparam logic [7:0] CMD_NONE = 8'h00;
	localparam logic [3:0] FRAME_LAST = 4'h9;
	typedef enum logic [1:0] {VAR_BASIC = 2'b00, VAR_EXPAN = 2'b01, VAR_NET = 2'b10} absw_variant_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11} absw_rx_t;
	typedef struct packed {
		logic key_on;
		logic tog_a;
		logic tog_b;
		logic sys_btn;
	} absw_panel_t;
	typedef struct packed {
		absw_variant_t variant;
		logic sec_en;
		logic [3:0] sec_code;
		logic safe_mode;
		logic first_rack;
		logic card1_present;
	} absw_cfg_t;
endpackage : absw_pkg

// >>> rtl/absw_ctrl.sv
// Control logic of the A/B switch rack controller
// Overview of operation
// [R1] Panel lock off: controller and card toggles are ignored.
// [R2] Serial and network switch commands still act while locked.
// [R3] Card toggle A drives card to A; A lamp lights when done.
// [R4] Card toggle B drives card to B; B lamp lights when done.
// [R5] Controller toggle switches every card of this rack.
// [R6] Toggle with system button held switches all chained racks.
// [R7] Activity lamp blinks on panel rack/system switch or remote command; the code does not blink on S status or control line commands.
// [R8] Basic serial input: 2400 baud, 8 data bits, no parity, 1 stop.
// [R9] Upper-case A, B switch system, S asks status; carriage return ends.
// [R10] Sender may prefix each command with the security character.
// [R11] Status answered only by card 1 in the first rack.
// [R12] Expansion variant forwards commands without acting on them.
// [R13] Network variant runs 9600 bps and ignores one-letter commands.
// [R14] Control line +12 V switches system to A, -12 V to B.
// [R15] Local system switch drives control line +10 V for A, -10 V for B.
// [R16] Network variant waits 30 s self test before console is ready.
// [R17] Network settings apply only after save followed by reset.
// [R18] A powered card lights exactly one of its A or B lamps.
// [R19] With security on, only commands after the security character act.
// [R20] Safe mode blocks serial switching but still answers status.
// [R21] Unrecognised sequences before carriage return are discarded.
// [R22] Lamps follow only the position reported by the switching element.
module absw_ctrl
	import absw_pkg::*;
#(
	parameter int NCARDS = 16,
	parameter int BAUD_BASIC_CYC_P = BAUD_BASIC_CYC,
	parameter int BAUD_NET_CYC_P = BAUD_NET_CYC,
	parameter int BOOT_CYC_P = BOOT_CYC,
	parameter int BLINK_CYC_P = BLINK_CYC
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire absw_pkg::absw_panel_t PANEL,
	input wire absw_pkg::absw_cfg_t CFG,
	input wire logic [NCARDS-1:0] CARD_TOG_A,
	input wire logic [NCARDS-1:0] CARD_TOG_B,
	input wire logic [NCARDS-1:0] CARD_AT_A,
	input wire logic [NCARDS-1:0] CARD_AT_B,
	input wire logic SYSCTL_IN_POS,
	input wire logic SYSCTL_IN_NEG,
	input wire logic RXD,
	input wire logic NET_SW_A,
	input wire logic NET_SW_B,
	input wire logic NET_PARAM_WR,
	input wire logic [7:0] NET_PARAM,
	input wire logic NET_SAVE,
	input wire logic NET_REBOOT,
	output logic [NCARDS-1:0] CARD_DRIVE_A,
	output logic [NCARDS-1:0] CARD_DRIVE_B,
	output logic [NCARDS-1:0] LED_A,
	output logic [NCARDS-1:0] LED_B,
	output logic ACTIVITY_LED,
	output logic POWER_INDICATOR,
	output logic SYSCTL_OUT_POS,
	output logic SYSCTL_OUT_NEG,
	output logic TXD,
	output logic FWD_TXD,
	output logic CONSOLE_READY,
	output logic [7:0] NET_PARAM_ACTIVE
);
	import absw_pkg::*;

	localparam int W = 7 + 4 * NCARDS;
	localparam int RXD_BIT = 6;
	localparam logic [W-1:0] SYNC_INIT = W'(1) << RXD_BIT;
	localparam logic [15:0] BAUD_B = 16'(BAUD_BASIC_CYC_P);
	localparam logic [15:0] BAUD_N = 16'(BAUD_NET_CYC_P);
	localparam logic [30:0] BOOT_LAST = 31'(BOOT_CYC_P - 1);
	localparam logic [26:0] BLINK_LOAD = 27'(BLINK_CYC_P);
	localparam logic [2:0] BIT_LAST = 3'(DATA_BITS - 1);

	// Three-stage synchronisers; a level is taken once stages two and three agree
	logic [W-1:0] s1_ff, s2_ff, s3_ff, f_ff, fp_ff;
	wire [W-1:0] async_in = {CARD_AT_B, CARD_AT_A, CARD_TOG_B, CARD_TOG_A, RXD, SYSCTL_IN_NEG, SYSCTL_IN_POS, PANEL};
	for (genvar i = 0; i < W; i++) begin : g_sync
		always_ff @(posedge CLK) begin
			if (RESET) begin
				s1_ff[i] <= SYNC_INIT[i];
				s2_ff[i] <= SYNC_INIT[i];
				s3_ff[i] <= SYNC_INIT[i];
				f_ff[i] <= SYNC_INIT[i];
				fp_ff[i] <= SYNC_INIT[i];
			end else begin
				s1_ff[i] <= async_in[i];
				s2_ff[i] <= s1_ff[i];
				s3_ff[i] <= s2_ff[i];
				f_ff[i] <= (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : f_ff[i];
				fp_ff[i] <= f_ff[i];
			end
		end
	end

	// Named views of the filtered inputs
	wire [W-1:0] rise = f_ff & ~fp_ff;
	wire absw_panel_t pf = f_ff[3:0];
	absw_panel_t pr;
	assign pr = rise[3:0];
	wire ctl_pos_rise = rise[4];
	wire ctl_neg_rise = rise[5];
	wire rxd_f = f_ff[RXD_BIT];
	wire [NCARDS-1:0] tog_a_rise = rise[7 +: NCARDS];
	wire [NCARDS-1:0] tog_b_rise = rise[7 + NCARDS +: NCARDS];
	wire [NCARDS-1:0] at_a_f = f_ff[7 + 2 * NCARDS +: NCARDS];
	wire [NCARDS-1:0] at_b_f = f_ff[7 + 3 * NCARDS +: NCARDS];
	wire is_basic = CFG.variant == VAR_BASIC;
	wire is_net = CFG.variant == VAR_NET;

	// Panel requests, all gated by the lock key
	wire rack_a = pf.key_on & pr.tog_a; // [R1]
	wire rack_b = pf.key_on & pr.tog_b; // [R1]
	wire local_sys_a = rack_a & pf.sys_btn; // [R6]
	wire local_sys_b = rack_b & pf.sys_btn; // [R6]
	wire [NCARDS-1:0] card_a_evt = pf.key_on ? tog_a_rise : '0; // [R1] [R3]
	wire [NCARDS-1:0] card_b_evt = pf.key_on ? tog_b_rise : '0; // [R1] [R4]

	// Control line input is ignored while this rack drives it, else it hears itself
	logic sysctl_pos_ff, sysctl_neg_ff;
	wire driving = sysctl_pos_ff | sysctl_neg_ff;
	wire ctl_a = ctl_pos_rise & ~driving; // [R14]
	wire ctl_b = ctl_neg_rise & ~driving; // [R14]

	// Serial receiver, sampling mid-bit; reload is one short so a bit lasts exactly baud cycles
	absw_rx_t rx_st_ff;
	logic [15:0] rx_cnt_ff;
	logic [2:0] rx_bit_ff;
	logic [7:0] rx_sh_ff;
	logic rx_vld_ff;
	wire [15:0] baud = is_net ? BAUD_N : BAUD_B; // [R8] [R13]
	wire rx_tick = rx_cnt_ff == 16'h0000;
	always_ff @(posedge CLK) begin
		if (RESET) begin
			rx_st_ff <= RX_IDLE;
			rx_cnt_ff <= 16'h0000;
			rx_bit_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			rx_vld_ff <= 1'b0;
		end else begin
			rx_vld_ff <= 1'b0;
			rx_cnt_ff <= rx_tick ? baud - 16'h0001 : rx_cnt_ff - 16'h0001;
			case (rx_st_ff)
				RX_IDLE: begin
					rx_cnt_ff <= {1'b0, baud[15:1]};
					if (!rxd_f) rx_st_ff <= RX_START;
				end
				RX_START: if (rx_tick) begin
					rx_st_ff <= rxd_f ? RX_IDLE : RX_DATA;
					rx_bit_ff <= 3'h0;
				end
				RX_DATA: if (rx_tick) begin
					rx_sh_ff <= {rxd_f, rx_sh_ff[7:1]}; // [R8] LSB first, no parity
					rx_bit_ff <= rx_bit_ff + 3'h1;
					if (rx_bit_ff == BIT_LAST) rx_st_ff <= RX_STOP;
				end
				RX_STOP: if (rx_tick) begin
					rx_vld_ff <= rxd_f; // [R8] Framing error drops the byte
					rx_st_ff <= RX_IDLE;
				end
				default: rx_st_ff <= RX_IDLE;
			endcase
		end
	end

	// Command parser; only the basic variant interprets characters
	logic [7:0] cmd_ff;
	logic sec_ok_ff, bad_ff;
	wire [7:0] sec_ch = SEC_BASE + {4'h0, CFG.sec_code};
	wire byte_in = rx_vld_ff & is_basic; // [R12] [R13]
	wire is_cr = rx_sh_ff == CH_CR;
	wire is_cmd = rx_sh_ff == CH_A || rx_sh_ff == CH_B || rx_sh_ff == CH_S; // [R9]
	wire exec = byte_in & is_cr & ~bad_ff & (cmd_ff != CMD_NONE); // [R9] [R21]
	wire ser_a = exec & (cmd_ff == CH_A) & ~CFG.safe_mode; // [R20]
	wire ser_b = exec & (cmd_ff == CH_B) & ~CFG.safe_mode; // [R20]
	wire ser_s = exec & (cmd_ff == CH_S); // [R20] Status still allowed
	always_ff @(posedge CLK) begin
		if (RESET || (byte_in && is_cr)) begin
			cmd_ff <= CMD_NONE;
			sec_ok_ff <= 1'b0;
			bad_ff <= 1'b0;
		end else if (byte_in) begin
			if (bad_ff || cmd_ff != CMD_NONE) bad_ff <= 1'b1; // [R21]
			else if (rx_sh_ff == sec_ch && !sec_ok_ff) sec_ok_ff <= 1'b1; // [R10]
			else if (is_cmd && (sec_ok_ff || !CFG.sec_en)) cmd_ff <= rx_sh_ff; // [R19]
			else bad_ff <= 1'b1; // [R21]
		end
	end

	// System and rack level requests from every source
	wire sys_a = local_sys_a | ser_a | ctl_a | NET_SW_A; // [R2] [R6] [R14]
	wire sys_b = local_sys_b | ser_b | ctl_b | NET_SW_B; // [R2] [R6] [R14]
	wire all_a = sys_a | rack_a; // [R5]
	wire all_b = sys_b | rack_b; // [R5]
	wire [NCARDS-1:0] req_a = {NCARDS{all_a}} | card_a_evt;
	wire [NCARDS-1:0] req_b = ({NCARDS{all_b}} | card_b_evt) & ~req_a;

	// Per card: drive the element until it reports arrival, lamps follow the report
	logic [NCARDS-1:0] drv_a_ff, drv_b_ff, led_a_ff, led_b_ff;
	for (genvar c = 0; c < NCARDS; c++) begin : g_card
		always_ff @(posedge CLK) begin
			if (RESET) begin
				drv_a_ff[c] <= 1'b0;
				drv_b_ff[c] <= 1'b0;
				led_a_ff[c] <= 1'b1;
				led_b_ff[c] <= 1'b0;
			end else begin
				drv_a_ff[c] <= req_a[c] | (drv_a_ff[c] & ~at_a_f[c] & ~req_b[c]); // [R3]
				drv_b_ff[c] <= req_b[c] | (drv_b_ff[c] & ~at_b_f[c] & ~req_a[c]); // [R4]
				if (at_a_f[c] != at_b_f[c]) begin
					led_a_ff[c] <= at_a_f[c]; // [R22] [R18]
					led_b_ff[c] <= at_b_f[c]; // [R22] [R18]
				end
			end
		end
	end

	// Control line drive held while the local system switch is held
	always_ff @(posedge CLK) begin
		if (RESET) begin
			sysctl_pos_ff <= 1'b0;
			sysctl_neg_ff <= 1'b0;
		end else begin
			sysctl_pos_ff <= local_sys_a | (sysctl_pos_ff & pf.key_on & pf.sys_btn & pf.tog_a); // [R15]
			sysctl_neg_ff <= local_sys_b | (sysctl_neg_ff & pf.key_on & pf.sys_btn & pf.tog_b); // [R15]
		end
	end

	// Activity blink; a fixed lamp time makes single-cycle events visible
	logic [26:0] blink_ff;
	wire blink_go = rack_a | rack_b | ser_a | ser_b | NET_SW_A | NET_SW_B; // [R7]
	always_ff @(posedge CLK) begin
		if (RESET) blink_ff <= 27'h0;
		else if (blink_go) blink_ff <= BLINK_LOAD; // [R7]
		else if (blink_ff != 27'h0) blink_ff <= blink_ff - 27'h1;
	end

	// Status reply: position letter of card 1 then carriage return
	logic [9:0] tx_sh_ff;
	logic [3:0] tx_bit_ff;
	logic [15:0] tx_cnt_ff;
	logic tx_busy_ff, tx_cr_ff;
	wire status_ok = ser_s & CFG.first_rack & CFG.card1_present & ~tx_busy_ff; // [R11]
	wire [7:0] reply = led_a_ff[0] ? CH_A : CH_B;
	always_ff @(posedge CLK) begin
		if (RESET) begin
			tx_sh_ff <= 10'h3FF;
			tx_bit_ff <= 4'h0;
			tx_cnt_ff <= 16'h0000;
			tx_busy_ff <= 1'b0;
			tx_cr_ff <= 1'b0;
		end else if (status_ok) begin
			tx_sh_ff <= {1'b1, reply, 1'b0}; // [R11]
			tx_bit_ff <= 4'h0;
			tx_cnt_ff <= baud;
			tx_busy_ff <= 1'b1;
			tx_cr_ff <= 1'b1;
		end else if (tx_busy_ff) begin
			tx_cnt_ff <= tx_cnt_ff - 16'h0001;
			if (tx_cnt_ff == 16'h0001) begin
				tx_cnt_ff <= baud;
				tx_bit_ff <= tx_bit_ff + 4'h1;
				tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
				if (tx_bit_ff == FRAME_LAST) begin
					tx_bit_ff <= 4'h0;
					tx_sh_ff <= {1'b1, CH_CR, 1'b0};
					tx_busy_ff <= tx_cr_ff;
					tx_cr_ff <= 1'b0;
				end
			end
		end
	end

	// Network boot delay and staged parameters
	logic [30:0] boot_ff;
	logic [7:0] staged_ff, saved_ff, active_ff;
	logic ready_ff;
	always_ff @(posedge CLK) begin
		if (RESET || (NET_REBOOT && is_net)) begin
			boot_ff <= 31'h0;
			ready_ff <= 1'b0;
		end else if (is_net && !ready_ff) begin
			boot_ff <= boot_ff + 31'h1;
			ready_ff <= boot_ff == BOOT_LAST; // [R16]
		end
	end
	always_ff @(posedge CLK) begin
		if (RESET) begin
			staged_ff <= 8'h00;
			saved_ff <= 8'h00;
			active_ff <= 8'h00;
		end else if (is_net) begin
			if (NET_PARAM_WR) staged_ff <= NET_PARAM;
			if (NET_SAVE) saved_ff <= staged_ff; // [R17]
			if (NET_REBOOT) active_ff <= saved_ff; // [R17]
		end
	end

	// Output flops
	always_ff @(posedge CLK) begin
		if (RESET) begin
			POWER_INDICATOR <= 1'b0;
			ACTIVITY_LED <= 1'b0;
			TXD <= 1'b1;
			FWD_TXD <= 1'b1;
		end else begin
			POWER_INDICATOR <= 1'b1;
			ACTIVITY_LED <= blink_ff != 27'h0;
			TXD <= tx_busy_ff ? tx_sh_ff[0] : 1'b1;
			FWD_TXD <= is_net ? 1'b1 : rxd_f; // [R12] Chain passes characters on
		end
	end
	assign CARD_DRIVE_A = drv_a_ff;
	assign CARD_DRIVE_B = drv_b_ff;
	assign LED_A = led_a_ff;
	assign LED_B = led_b_ff;
	assign SYSCTL_OUT_POS = sysctl_pos_ff;
	assign SYSCTL_OUT_NEG = sysctl_neg_ff;
	assign CONSOLE_READY = ready_ff;
	assign NET_PARAM_ACTIVE = active_ff;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	property p_lock; !pf.key_on |-> !rack_a && !rack_b && card_a_evt == '0; endproperty
	a_lock: assert property (p_lock) else $error("panel acted while locked"); // [R1]
	property p_card_a; req_a[0] |=> CARD_DRIVE_A[0] && !CARD_DRIVE_B[0]; endproperty
	a_card_a: assert property (p_card_a) else $error("card not driven to A"); // [R3]
	property p_lamp; $rose(LED_A[0]) |-> $past(at_a_f[0]) && !LED_B[0]; endproperty
	a_lamp: assert property (p_lamp) else $error("lamp changed without report"); // [R22]
	property p_one; (LED_A ^ LED_B) == '1; endproperty
	a_one: assert property (p_one) else $error("lamps not exclusive"); // [R18]
	property p_blink; blink_go |=> ##1 ACTIVITY_LED; endproperty
	a_blink: assert property (p_blink) else $error("activity lamp missed"); // [R7]
	property p_safe; ser_a || ser_b |-> is_basic && !CFG.safe_mode; endproperty
	a_safe: assert property (p_safe) else $error("switch in safe mode"); // [R20]
	property p_stat; $rose(tx_busy_ff) |-> $past(CFG.first_rack && CFG.card1_present); endproperty
	a_stat: assert property (p_stat) else $error("status from wrong card"); // [R11]
	property p_out; local_sys_a |=> SYSCTL_OUT_POS && !SYSCTL_OUT_NEG; endproperty
	a_out: assert property (p_out) else $error("control line not driven"); // [R15]
	property p_sec; exec && CFG.sec_en && cmd_ff != CH_S |-> sec_ok_ff; endproperty
	a_sec: assert property (p_sec) else $error("command without security char"); // [R19]
endmodule : absw_ctrl

// >>> tb/absw_term.sv
// Serial terminal model: 8N1 sender onto RXD and receiver of TXD
module absw_term #(
	parameter int BIT = 16
) (
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] din,
	input wire logic txd,
	output logic rxd,
	output logic busy,
	output logic [7:0] rx_byte,
	output logic rx_stb
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] f;
	// Sender: start low, data LSB first, one stop; line idles high
	initial begin
		rxd = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (go) begin
				busy <= 1'b1;
				f = {1'b1, din, 1'b0};
				for (int i = 0; i < 10; i++) begin
					rxd <= f[i];
					repeat (BIT) @(posedge clk);
				end
				busy <= 1'b0;
			end
		end
	end
	// Receiver samples mid bit; a bad stop bit drops the byte
	initial begin
		rx_stb = 1'b0;
		rx_byte = 8'h00;
		forever begin
			@(negedge txd);
			repeat (BIT / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clk);
				rx_byte[i] <= txd;
			end
			repeat (BIT) @(posedge clk);
			rx_stb <= txd;
			@(posedge clk);
			rx_stb <= 1'b0;
		end
	end
endmodule : absw_term

// >>> tb/absw_ctrl_tb.sv
// Self-checking bench of the A/B switch rack controller
module absw_ctrl_tb;
	import absw_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int N = 16;
	logic clk, rst, go, busy, rx_stb, rxd, sc_p, sc_n, nsa, nsb, nwr, nsv, nrb;
	logic act, power_indicator, so_p, so_n, txd, ftx, crdy;
	logic [7:0] din, rx_byte, nprm, pact, p;
	logic [N-1:0] tga, tgb, at_a, at_b, dra, drb, la, lb, m_a;
	logic [3:0] k;
	logic [31:0] lf;
	absw_panel_t pnl;
	absw_cfg_t cfg;
	int n_mismatch, num_checks, cyc, nf;
	int n_fall = 0;
	logic [7:0] rxq[$];
	// Short counts keep the run brief; expectations use the same values
	absw_ctrl #(.NCARDS(N), .BAUD_BASIC_CYC_P(16), .BAUD_NET_CYC_P(8), .BOOT_CYC_P(50), .BLINK_CYC_P(10)) dut_u (
		.CLK(clk), .RESET(rst), .PANEL(pnl), .CFG(cfg), .CARD_TOG_A(tga), .CARD_TOG_B(tgb),
		.CARD_AT_A(at_a), .CARD_AT_B(at_b), .SYSCTL_IN_POS(sc_p), .SYSCTL_IN_NEG(sc_n), .RXD(rxd),
		.NET_SW_A(nsa), .NET_SW_B(nsb), .NET_PARAM_WR(nwr), .NET_PARAM(nprm), .NET_SAVE(nsv),
		.NET_REBOOT(nrb), .CARD_DRIVE_A(dra), .CARD_DRIVE_B(drb), .LED_A(la), .LED_B(lb),
		.ACTIVITY_LED(act), .POWER_INDICATOR(power_indicator), .SYSCTL_OUT_POS(so_p), .SYSCTL_OUT_NEG(so_n),
		.TXD(txd), .FWD_TXD(ftx), .CONSOLE_READY(crdy), .NET_PARAM_ACTIVE(pact));
	absw_term #(.BIT(16)) term_u (.clk(clk), .go(go), .din(din), .txd(txd), .rxd(rxd), .busy(busy),
		.rx_byte(rx_byte), .rx_stb(rx_stb));
	// Clock, 20 ns period
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Switching elements report their position one cycle after being driven
	always_ff @(posedge clk) begin
		at_a <= rst ? '1 : dra | (at_a & ~drb);
		at_b <= rst ? '0 : drb | (at_b & ~dra);
	end
	// Falling edges on the forwarded chain output
	always @(negedge ftx)
		n_fall++;
	// Collect reply bytes; cut a hang short
	always @(posedge clk) begin
		if (rx_stb)
			rxq.push_back(rx_byte);
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			final_report();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic send(input logic [7:0] b);
		go <= 1'b1;
		din <= b;
		tick(2);
		go <= 1'b0;
		while (busy)
			@(posedge clk);
	endtask : send
	task automatic cmd(input string s);
		for (int i = 0; i < s.len(); i++)
			send(s[i]);
		send(CH_CR);
	endtask : cmd
	// Lamps against the model; a refused request simply never moves them
	task automatic led();
		for (int i = 0; i < 60 && la !== m_a; i++)
			@(posedge clk);
		chk(la, m_a);
		chk(lb, ~m_a);
	endtask : led
	task automatic stat(input int n);
		rxq.delete();
		cmd("S");
		for (int i = 0; i < 400 && rxq.size() < 2; i++)
			@(posedge clk);
		chk(16'(rxq.size()), 16'(n));
		if (n == 2) begin
			chk(rxq[0], m_a[0] ? CH_A : CH_B);
			chk(rxq[1], CH_CR);
		end
	endtask : stat
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	// Main sequence
	initial begin
		rst = 1'b1;
		{go, sc_p, sc_n, nsa, nsb, nwr, nsv, nrb} = '0;
		{tga, tgb, din, nprm, pnl, cfg, n_mismatch, num_checks, cyc} = '0;
		cfg.first_rack = 1'b1;
		cfg.card1_present = 1'b1;
		lf = lfsr(32'h749e);
		k = lf[3:0];
		m_a = '1;
		tick(20);
		rst <= 1'b0;
		tick(6);
		chk(power_indicator, 1'b1);
		led();
		// Locked panel: toggles leave every card alone
		pnl <= 4'b0010;
		tgb[k] <= 1'b1;
		tick(20);
		{pnl, tgb} <= '0;
		tick(8);
		led();
		// Unlocked: controller toggle B with system button (key, tog_a, tog_b, btn)
		pnl <= 4'b1011;
		for (int i = 0; i < 20 && act !== 1'b1; i++)
			@(posedge clk);
		chk(act, 1'b1);
		chk({so_p, so_n}, 2'b01);
		m_a = '0;
		led();
		pnl <= 4'b1000;
		tga[k] <= 1'b1;
		m_a[k] = 1'b1;
		led();
		tga <= '0;
		tick(8);
		// Controller toggle A with system button: whole rack to A, line driven positive
		pnl <= 4'b1101;
		m_a = '1;
		for (int i = 0; i < 20 && so_p !== 1'b1; i++)
			@(posedge clk);
		chk({so_p, so_n}, 2'b10);
		led();
		pnl <= 4'b0000;
		// Serial commands with the panel locked
		cmd("a");
		led();
		cmd("AB");
		led();
		cmd("B");
		m_a = '0;
		led();
		stat(2);
		cfg.first_rack <= 1'b0;
		stat(0);
		cfg.first_rack <= 1'b1;
		cfg.safe_mode <= 1'b1;
		cmd("A");
		led();
		stat(2);
		cfg.safe_mode <= 1'b0;
		cfg.sec_en <= 1'b1;
		cfg.sec_code <= 4'(lf[7:4] % 4'hA);
		cmd("A");
		led();
		send(SEC_BASE + {4'h0, cfg.sec_code});
		cmd("A");
		m_a = '1;
		led();
		cfg.sec_en <= 1'b0;
		// Control line levels
		sc_n <= 1'b1;
		m_a = '0;
		led();
		sc_n <= 1'b0;
		tick(8);
		sc_p <= 1'b1;
		m_a = '1;
		led();
		sc_p <= 1'b0;
		cfg.variant <= VAR_EXPAN;
		nf = n_fall;
		cmd("B");
		led();
		// 8N1 frames of B and CR hold three falling edges each
		chk(16'(n_fall - nf), 16'd6);
		// Network variant: staged settings, save then reboot
		cfg.variant <= VAR_NET;
		p = lf[15:8] | 8'h01;
		nwr <= 1'b1;
		nprm <= p;
		tick(1);
		nwr <= 1'b0;
		nrb <= 1'b1;
		tick(1);
		nrb <= 1'b0;
		tick(2);
		chk(pact, 8'h00);
		chk(crdy, 1'b0);
		nsv <= 1'b1;
		tick(1);
		nsv <= 1'b0;
		nrb <= 1'b1;
		tick(1);
		nrb <= 1'b0;
		tick(2);
		chk(pact, p);
		for (int i = 0; i < 80 && crdy !== 1'b1; i++)
			@(posedge clk);
		chk(crdy, 1'b1);
		nsb <= 1'b1;
		tick(1);
		nsb <= 1'b0;
		m_a = '0;
		led();
		final_report();
	end
endmodule : absw_ctrl_tb
